// ---- shared/uecsr_pkg.sv ----
//==========================================================
// Endpoint CSR constants
package uecsr_pkg;
   // Endpoint count, slot 0 is endpoint 2, slot 1 is endpoint 3
   localparam int unsigned UECSR_NUM_EP = 2;
   localparam int unsigned UECSR_DW = 32;
   // Register byte addresses
   localparam logic [31:0] UECSR_EP2_ADDR = 32'hf00e0020;
   localparam logic [31:0] UECSR_EP3_ADDR = 32'hf00e0024;
   // Reset value shared by both endpoint registers
   localparam logic [31:0] UECSR_RESET = 32'h00000401;
   //==========================================================
   // Field positions
   localparam int unsigned UECSR_B_MAX_PACKET_SIZE_LO = 0;
   localparam int unsigned UECSR_B_MAX_PACKET_SIZE_HI = 3;
   localparam int unsigned UECSR_B_MAX_PACKET_SIZE_WE = 7;
   localparam int unsigned UECSR_B_TYPE_LO = 8;
   localparam int unsigned UECSR_B_OUT_ISO = 8;
   localparam int unsigned UECSR_B_OUT_ACLR = 9;
   localparam int unsigned UECSR_B_DIR_IN = 10;
   localparam int unsigned UECSR_B_IN_ISO = 11;
   localparam int unsigned UECSR_B_IN_ASET = 12;
   localparam int unsigned UECSR_B_TYPE_HI = 12;
   localparam int unsigned UECSR_B_TYPE_WE = 15;
   localparam int unsigned UECSR_B_OUT_RDY = 16;
   localparam int unsigned UECSR_B_OUT_FULL = 17;
   localparam int unsigned UECSR_B_OUT_OVR = 18;
   localparam int unsigned UECSR_B_OUT_DERR = 19;
   localparam int unsigned UECSR_B_OUT_FLUSH = 20;
   localparam int unsigned UECSR_B_OUT_SSTL = 21;
   localparam int unsigned UECSR_B_OUT_STSENT = 22;
   localparam int unsigned UECSR_B_OUT_TCLR = 23;
   localparam int unsigned UECSR_B_IN_RDY = 24;
   localparam int unsigned UECSR_B_IN_NEMP = 25;
   localparam int unsigned UECSR_B_IN_UNDR = 26;
   localparam int unsigned UECSR_B_IN_FLUSH = 27;
   localparam int unsigned UECSR_B_IN_SSTL = 28;
   localparam int unsigned UECSR_B_IN_STSENT = 29;
   localparam int unsigned UECSR_B_IN_TCLR = 30;
   // Packet size unit as a byte shift (8 bytes) and largest legal code
   localparam logic [2:0] UECSR_MAX_PACKET_SIZE_UNIT_SH = 3'h3;
   localparam logic [3:0] UECSR_MAX_PACKET_SIZE_LIMIT = 4'h8;
endpackage : uecsr_pkg

// ---- rtl/uecsr_top.sv ----
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
//==========================================================
module uecsr_top
   import uecsr_pkg::*;
(
   input wire logic i_sys_clk, // System clock
   input wire logic i_srst, // Sync reset, high
   input wire logic [31:0] i_addr, // Register byte address
   input wire logic [31:0] i_wdata, // Write data
   input wire logic i_wr_stb, // Write strobe
   input wire logic i_rd_stb, // Read strobe
   output logic [31:0] o_rdata, // Read data, cycle after strobe
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_out_pkt_rcvd, // Packet loaded
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_out_fifo_full, // Level
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_out_overrun, // Data at full
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_out_data_err, // Bad packet
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_out_stall_tx, // STALL sent
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_out_flush_done, // Flushed
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_out_unloaded, // Last data read
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_in_pkt_sent, // Packet sent
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_in_fifo_not_empty, // Level
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_in_token, // IN token seen
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_in_stall_tx, // STALL sent
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_in_flush_done, // Flushed
   input wire logic [uecsr_pkg::UECSR_NUM_EP-1:0] i_in_max_packet_size_loaded, // Full pkt in
   output logic [uecsr_pkg::UECSR_NUM_EP-1:0] o_dir_in, // Direction is IN
   output logic [uecsr_pkg::UECSR_NUM_EP-1:0] o_out_iso, // OUT iso active
   output logic [uecsr_pkg::UECSR_NUM_EP-1:0] o_in_iso, // IN iso active
   output logic [uecsr_pkg::UECSR_NUM_EP-1:0] o_out_send_stall, // Stall OUT
   output logic [uecsr_pkg::UECSR_NUM_EP-1:0] o_in_send_stall, // Stall IN
   output logic [uecsr_pkg::UECSR_NUM_EP-1:0] o_out_fifo_flush, // Flush request
   output logic [uecsr_pkg::UECSR_NUM_EP-1:0] o_in_fifo_flush, // Flush request
   output logic [uecsr_pkg::UECSR_NUM_EP-1:0] o_out_toggle_clear, // Pulse
   output logic [uecsr_pkg::UECSR_NUM_EP-1:0] o_in_toggle_clear, // Pulse
   output logic [uecsr_pkg::UECSR_NUM_EP-1:0] o_in_packet_ready, // Ready to send
   output logic [uecsr_pkg::UECSR_NUM_EP-1:0][6:0] o_max_pkt_bytes // Size in bytes
);
   import uecsr_pkg::*;

   //==========================================================
   // Address decode
   // Only the two endpoint words decode; anything else reads zero
   function automatic logic ep_hit(input logic [31:0] addr, input int unsigned ep);
      logic [31:0] base;
      base = (ep == 0) ? UECSR_EP2_ADDR : UECSR_EP3_ADDR;
      return addr == base;
   endfunction : ep_hit

   //==========================================================
   // Register state, one slot per endpoint
   logic [UECSR_NUM_EP-1:0][3:0] max_packet_size_r;
   logic [UECSR_NUM_EP-1:0] out_iso_r;
   logic [UECSR_NUM_EP-1:0] out_aclr_r;
   logic [UECSR_NUM_EP-1:0] dir_in_r;
   logic [UECSR_NUM_EP-1:0] in_iso_r;
   logic [UECSR_NUM_EP-1:0] in_aset_r;
   logic [UECSR_NUM_EP-1:0] out_rdy_r;
   logic [UECSR_NUM_EP-1:0] out_rdy_nxt;
   logic [UECSR_NUM_EP-1:0] out_ovr_r;
   logic [UECSR_NUM_EP-1:0] out_derr_r;
   logic [UECSR_NUM_EP-1:0] out_flush_r;
   logic [UECSR_NUM_EP-1:0] out_sstl_r;
   logic [UECSR_NUM_EP-1:0] out_stsent_r;
   logic [UECSR_NUM_EP-1:0] out_tclr_r;
   logic [UECSR_NUM_EP-1:0] in_rdy_r;
   logic [UECSR_NUM_EP-1:0] in_undr_r;
   logic [UECSR_NUM_EP-1:0] in_flush_r;
   logic [UECSR_NUM_EP-1:0] in_sstl_r;
   logic [UECSR_NUM_EP-1:0] in_stsent_r;
   logic [UECSR_NUM_EP-1:0] in_tclr_r;
   logic [UECSR_NUM_EP-1:0] wr_ep;
   logic [UECSR_NUM_EP-1:0] wr_out;
   logic [UECSR_NUM_EP-1:0] wr_in;
   logic [UECSR_NUM_EP-1:0][31:0] rd_word;
   logic [31:0] rdata_r;

   // Checks run on the system clock and sleep through reset, except a_reset_value
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   //==========================================================
   // Per-endpoint register logic
   for (genvar e = 0; e < UECSR_NUM_EP; e++) begin : g_ep
      // Direction-qualified write strobes, old direction decides
      assign wr_ep[e] = i_wr_stb && ep_hit(i_addr, e);
      assign wr_out[e] = wr_ep[e] && !dir_in_r[e];
      assign wr_in[e] = wr_ep[e] && dir_in_r[e];

      // Size field behind its own write enable
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            max_packet_size_r[e] <= UECSR_RESET[UECSR_B_MAX_PACKET_SIZE_HI:UECSR_B_MAX_PACKET_SIZE_LO];
         end else if (wr_ep[e] && i_wdata[UECSR_B_MAX_PACKET_SIZE_WE]) begin
            max_packet_size_r[e] <= i_wdata[UECSR_B_MAX_PACKET_SIZE_HI:UECSR_B_MAX_PACKET_SIZE_LO];
         end
      end

      // Type and direction group behind its own write enable
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            {in_aset_r[e], in_iso_r[e], dir_in_r[e], out_aclr_r[e], out_iso_r[e]} <=
               UECSR_RESET[UECSR_B_TYPE_HI:UECSR_B_TYPE_LO];
         end else if (wr_ep[e] && i_wdata[UECSR_B_TYPE_WE]) begin
            {in_aset_r[e], in_iso_r[e], dir_in_r[e], out_aclr_r[e], out_iso_r[e]} <=
               i_wdata[UECSR_B_TYPE_HI:UECSR_B_TYPE_LO];
         end
      end

      // OUT packet ready; engine set wins over software or auto clear
      assign out_rdy_nxt[e] = (i_out_pkt_rcvd[e] && !dir_in_r[e]) ||
         (out_rdy_r[e] && !((wr_out[e] && i_wdata[UECSR_B_OUT_RDY]) ||
         (out_aclr_r[e] && i_out_unloaded[e])));
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            out_rdy_r[e] <= 1'b0;
         end else begin
            out_rdy_r[e] <= out_rdy_nxt[e];
         end
      end

      // Error flag follows packet ready down, only in OUT iso
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            out_derr_r[e] <= 1'b0;
         end else if (i_out_data_err[e] && o_out_iso[e]) begin
            out_derr_r[e] <= 1'b1;
         end else if (out_rdy_r[e] && !out_rdy_nxt[e]) begin
            out_derr_r[e] <= 1'b0;
         end
      end

      // Overrun in OUT iso; write one to clear
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            out_ovr_r[e] <= 1'b0;
         end else if (i_out_overrun[e] && o_out_iso[e]) begin
            out_ovr_r[e] <= 1'b1;
         end else if (wr_out[e] && i_wdata[UECSR_B_OUT_OVR]) begin
            out_ovr_r[e] <= 1'b0;
         end
      end

      // Flush requests held until the engine reports done
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            out_flush_r[e] <= 1'b0;
            in_flush_r[e] <= 1'b0;
         end else begin
            out_flush_r[e] <= (wr_out[e] && i_wdata[UECSR_B_OUT_FLUSH]) ||
               (out_flush_r[e] && !i_out_flush_done[e]);
            in_flush_r[e] <= (wr_in[e] && i_wdata[UECSR_B_IN_FLUSH]) ||
               (in_flush_r[e] && !i_in_flush_done[e]);
         end
      end

      // Send-stall levels written directly by software
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            out_sstl_r[e] <= 1'b0;
            in_sstl_r[e] <= 1'b0;
         end else begin
            if (wr_out[e]) begin
               out_sstl_r[e] <= i_wdata[UECSR_B_OUT_SSTL];
            end
            if (wr_in[e]) begin
               in_sstl_r[e] <= i_wdata[UECSR_B_IN_SSTL];
            end
         end
      end

      // Stall-sent flags; engine report wins over write-one clear
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            out_stsent_r[e] <= 1'b0;
            in_stsent_r[e] <= 1'b0;
         end else begin
            out_stsent_r[e] <= (i_out_stall_tx[e] && !dir_in_r[e]) ||
               (out_stsent_r[e] && !(wr_out[e] && i_wdata[UECSR_B_OUT_STSENT]));
            in_stsent_r[e] <= (i_in_stall_tx[e] && dir_in_r[e]) ||
               (in_stsent_r[e] && !(wr_in[e] && i_wdata[UECSR_B_IN_STSENT]));
         end
      end

      // Toggle clears are one-cycle pulses, the bits read as zero
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            out_tclr_r[e] <= 1'b0;
            in_tclr_r[e] <= 1'b0;
         end else begin
            out_tclr_r[e] <= wr_out[e] && i_wdata[UECSR_B_OUT_TCLR];
            in_tclr_r[e] <= wr_in[e] && i_wdata[UECSR_B_IN_TCLR];
         end
      end

      // IN ready: stall blocks setting, sent packet or STALL clears
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            in_rdy_r[e] <= 1'b0;
         end else if (((wr_in[e] && i_wdata[UECSR_B_IN_RDY]) ||
               (in_aset_r[e] && dir_in_r[e] && i_in_max_packet_size_loaded[e])) && !in_sstl_r[e]) begin
            in_rdy_r[e] <= 1'b1;
         end else if (i_in_pkt_sent[e] || i_in_stall_tx[e]) begin
            in_rdy_r[e] <= 1'b0;
         end
      end

      // Underrun in IN iso; token set wins over clear
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            in_undr_r[e] <= 1'b0;
         end else begin
            in_undr_r[e] <= (i_in_token[e] && o_in_iso[e] && !in_rdy_r[e]) ||
               (in_undr_r[e] && !(wr_in[e] && i_wdata[UECSR_B_IN_UNDR]));
         end
      end

      // Engine-facing outputs; iso and send-stall levels gated by the selected direction
      assign o_dir_in[e] = dir_in_r[e];
      assign o_out_iso[e] = out_iso_r[e] && !dir_in_r[e];
      assign o_in_iso[e] = in_iso_r[e] && dir_in_r[e];
      assign o_out_send_stall[e] = out_sstl_r[e] && !dir_in_r[e];
      assign o_in_send_stall[e] = in_sstl_r[e] && dir_in_r[e];
      assign o_out_fifo_flush[e] = out_flush_r[e];
      assign o_in_fifo_flush[e] = in_flush_r[e];
      assign o_out_toggle_clear[e] = out_tclr_r[e];
      assign o_in_toggle_clear[e] = in_tclr_r[e];
      assign o_in_packet_ready[e] = in_rdy_r[e];
      // Size code scaled to bytes; codes above the limit pass through as stored
      assign o_max_pkt_bytes[e] = 7'(max_packet_size_r[e]) << UECSR_MAX_PACKET_SIZE_UNIT_SH;

      // Readback word; write-only, toggle and reserved bits read zero
      always_comb begin
         rd_word[e] = 32'h0;
         rd_word[e][UECSR_B_MAX_PACKET_SIZE_HI:UECSR_B_MAX_PACKET_SIZE_LO] = max_packet_size_r[e];
         rd_word[e][UECSR_B_OUT_ISO] = out_iso_r[e];
         rd_word[e][UECSR_B_OUT_ACLR] = out_aclr_r[e];
         rd_word[e][UECSR_B_DIR_IN] = dir_in_r[e];
         rd_word[e][UECSR_B_IN_ISO] = in_iso_r[e];
         rd_word[e][UECSR_B_IN_ASET] = in_aset_r[e];
         rd_word[e][UECSR_B_OUT_RDY] = out_rdy_r[e];
         rd_word[e][UECSR_B_OUT_FULL] = i_out_fifo_full[e] && !dir_in_r[e];
         rd_word[e][UECSR_B_OUT_OVR] = out_ovr_r[e];
         rd_word[e][UECSR_B_OUT_DERR] = out_derr_r[e];
         rd_word[e][UECSR_B_OUT_FLUSH] = out_flush_r[e];
         rd_word[e][UECSR_B_OUT_SSTL] = out_sstl_r[e];
         rd_word[e][UECSR_B_OUT_STSENT] = out_stsent_r[e];
         rd_word[e][UECSR_B_IN_RDY] = in_rdy_r[e];
         rd_word[e][UECSR_B_IN_NEMP] = i_in_fifo_not_empty[e] && dir_in_r[e];
         rd_word[e][UECSR_B_IN_UNDR] = in_undr_r[e];
         rd_word[e][UECSR_B_IN_FLUSH] = in_flush_r[e];
         rd_word[e][UECSR_B_IN_SSTL] = in_sstl_r[e];
         rd_word[e][UECSR_B_IN_STSENT] = in_stsent_r[e];
      end

      //==========================================================
      // Checks
      sequence s_size_write;
         wr_ep[e] && i_wdata[UECSR_B_MAX_PACKET_SIZE_WE];
      endsequence
      sequence s_out_pkt_in;
         i_out_pkt_rcvd[e] && !dir_in_r[e];
      endsequence

      a_size_guarded: assert property (wr_ep[e] && !i_wdata[UECSR_B_MAX_PACKET_SIZE_WE]
         |=> $stable(max_packet_size_r[e])) else $error("size changed without enable");
      a_size_loaded: assert property (s_size_write |=>
         max_packet_size_r[e] == $past(i_wdata[UECSR_B_MAX_PACKET_SIZE_HI:UECSR_B_MAX_PACKET_SIZE_LO]))
         else $error("size not loaded");
      a_type_guarded: assert property (wr_ep[e] && !i_wdata[UECSR_B_TYPE_WE]
         |=> $stable(dir_in_r[e]) && $stable(out_iso_r[e]) && $stable(in_iso_r[e]))
         else $error("type group changed without enable");
      a_out_rdy_set: assert property (s_out_pkt_in |=> out_rdy_r[e])
         else $error("packet ready not set");
      a_auto_clear: assert property (out_rdy_r[e] && out_aclr_r[e] && i_out_unloaded[e]
         && !i_out_pkt_rcvd[e] && !i_out_data_err[e] |=> !out_rdy_r[e] && !out_derr_r[e])
         else $error("auto clear missed");
      a_in_stall_blk: assert property (in_sstl_r[e] && !in_rdy_r[e]
         && !i_in_max_packet_size_loaded[e] |=> !in_rdy_r[e]) else $error("ready set while stalling");
      a_underrun_set: assert property (i_in_token[e] && dir_in_r[e] && in_iso_r[e]
         && !in_rdy_r[e] |=> in_undr_r[e]) else $error("underrun not flagged");
      a_tclr_pulse: assert property (wr_in[e] && i_wdata[UECSR_B_IN_TCLR]
         |=> o_in_toggle_clear[e] ##1 (!o_in_toggle_clear[e] ||
         $past(wr_in[e] && i_wdata[UECSR_B_IN_TCLR]))) else $error("toggle clear pulse wrong");
      a_flush_hold: assert property (o_out_fifo_flush[e] && !i_out_flush_done[e]
         |=> o_out_fifo_flush[e]) else $error("flush dropped early");
      a_unsel_ignore: assert property (wr_ep[e] && dir_in_r[e] && !i_out_stall_tx[e]
         |=> $stable(out_sstl_r[e]) && $stable(out_stsent_r[e]))
         else $error("OUT bits written in IN mode");
      a_stall_sent: assert property (i_in_stall_tx[e] && dir_in_r[e]
         && !i_in_max_packet_size_loaded[e] && !(wr_in[e] && i_wdata[UECSR_B_IN_RDY])
         |=> in_stsent_r[e] && !in_rdy_r[e]) else $error("IN stall sent not flagged");
   end

   //==========================================================
   // Read port: data valid only in the cycle after the strobe
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         rdata_r <= 32'h0;
      end else if (i_rd_stb && ep_hit(i_addr, 0)) begin
         rdata_r <= rd_word[0];
      end else if (i_rd_stb && ep_hit(i_addr, 1)) begin
         rdata_r <= rd_word[1];
      end else begin
         rdata_r <= 32'h0;
      end
   end
   // Registered so read data carry no address decode glitches
   assign o_rdata = rdata_r;

   a_reset_value: assert property (disable iff (1'b0) i_srst ##1 i_rd_stb &&
      i_addr == UECSR_EP3_ADDR && !i_wr_stb |=> o_rdata[15:0] == UECSR_RESET[15:0])
      else $error("endpoint 3 reset value wrong");
   a_read_window: assert property (!i_rd_stb |=> o_rdata == 32'h0)
      else $error("read data outside window");
endmodule : uecsr_top

// ---- rtl/uecsr_fix_note.sv ----
`timescale 1ns/1ps

// ---- tb/uecsr_engine_model.sv ----
`timescale 1ns/1ps
//==========================================================
// Serial engine stand-in: event pulses, FIFO levels, flush answers
module uecsr_engine_model
   import uecsr_pkg::*;
#(
   parameter int unsigned FLUSH_DLY = 3 // Flush done comes FLUSH_DLY+1 cycles after the request is seen
)(
   input wire logic i_sys_clk, // System clock
   input wire logic i_srst, // Sync reset, high
   input wire logic [1:0] i_out_fifo_flush, // OUT flush request
   input wire logic [1:0] i_in_fifo_flush, // IN flush request
   output logic [8:0][1:0] o_pulse, // Event pulses, one per kind
   output logic [1:0] o_full, // OUT FIFO full level
   output logic [1:0] o_nemp, // IN FIFO not empty level
   output logic [1:0] o_out_flush_done, // OUT flush finished
   output logic [1:0] o_in_flush_done // IN flush finished
);
   int unsigned ocnt [2];
   int unsigned icnt [2];
   // Quiet at start, no events and empty FIFOs
   initial begin
      o_pulse = '0;
      o_full = '0;
      o_nemp = '0;
   end
   // One event for one cycle, launched after an edge
   task automatic pulse(input int ep, input int k);
      @(posedge i_sys_clk);
      o_pulse[k][ep] <= 1'b1;
      @(posedge i_sys_clk);
      o_pulse[k][ep] <= 1'b0;
   endtask : pulse
   // FIFO levels as the engine would report them
   task automatic levels(input logic [1:0] f, input logic [1:0] n);
      @(posedge i_sys_clk);
      o_full <= f;
      o_nemp <= n;
   endtask : levels
   // Flush ends after a delay, as if a token were still in flight
   always_ff @(posedge i_sys_clk) begin
      for (int e = 0; e < 2; e++) begin
         o_out_flush_done[e] <= 1'b0;
         o_in_flush_done[e] <= 1'b0;
         if (i_srst || !i_out_fifo_flush[e]) ocnt[e] <= 0;
         else if (ocnt[e] == FLUSH_DLY) begin
            o_out_flush_done[e] <= 1'b1;
            ocnt[e] <= 0;
         end else ocnt[e] <= ocnt[e] + 1;
         if (i_srst || !i_in_fifo_flush[e]) icnt[e] <= 0;
         else if (icnt[e] == FLUSH_DLY) begin
            o_in_flush_done[e] <= 1'b1;
            icnt[e] <= 0;
         end else icnt[e] <= icnt[e] + 1;
      end
   end
endmodule : uecsr_engine_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin miscompares++; \
   $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module testbench;
   import uecsr_pkg::*;
   //==========================================================
   // Signals and model state
   logic i_sys_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [31:0] addr = '0, wdata = '0, rdata, a, d;
   logic wr_stb = 1'b0, rd_stb = 1'b0;
   logic [8:0][1:0] pulse;
   logic [1:0] full, nemp, ofd, ifd, dir_in, out_iso, in_iso, out_ss, in_ss;
   logic [1:0] out_fl, in_fl, out_tc, in_tc, in_rdy, exp_otc, exp_itc;
   logic [1:0][6:0] max_packet_size;
   logic [31:0] m [2];
   int miscompares = 0, n_compared = 0, seed = 11, cycles = 0, e;
   uecsr_top i_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(addr),
      .i_wdata(wdata), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rdata(rdata),
      .i_out_pkt_rcvd(pulse[0]), .i_out_fifo_full(full), .i_out_overrun(pulse[1]),
      .i_out_data_err(pulse[2]), .i_out_stall_tx(pulse[3]), .i_out_flush_done(ofd),
      .i_out_unloaded(pulse[4]), .i_in_pkt_sent(pulse[5]), .i_in_fifo_not_empty(nemp),
      .i_in_token(pulse[6]), .i_in_stall_tx(pulse[7]), .i_in_flush_done(ifd),
      .i_in_max_packet_size_loaded(pulse[8]), .o_dir_in(dir_in), .o_out_iso(out_iso),
      .o_in_iso(in_iso), .o_out_send_stall(out_ss), .o_in_send_stall(in_ss),
      .o_out_fifo_flush(out_fl), .o_in_fifo_flush(in_fl), .o_out_toggle_clear(out_tc),
      .o_in_toggle_clear(in_tc), .o_in_packet_ready(in_rdy), .o_max_pkt_bytes(max_packet_size));
   uecsr_engine_model i_eng (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
      .i_out_fifo_flush(out_fl), .i_in_fifo_flush(in_fl), .o_pulse(pulse),
      .o_full(full), .o_nemp(nemp), .o_out_flush_done(ofd), .o_in_flush_done(ifd));
   // Clock and hang guard; the run needs a few hundred cycles
   always #50 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end
   //==========================================================
   // Checks against the model
   function automatic logic [31:0] rd_exp(input int k);
      logic [31:0] v;
      v = m[k] & 32'h3d7d1f0f;
      v[17] = full[k] & ~m[k][10];
      v[25] = nemp[k] & m[k][10];
      return v;
   endfunction : rd_exp
   task automatic check_all();
      for (int k = 0; k < 2; k++) begin
         `CHK("dir", m[k][10], dir_in[k])
         `CHK("out_iso", m[k][8] & ~m[k][10], out_iso[k])
         `CHK("in_iso", m[k][11] & m[k][10], in_iso[k])
         `CHK("out_stall", m[k][21] & ~m[k][10], out_ss[k])
         `CHK("in_stall", m[k][28] & m[k][10], in_ss[k])
         `CHK("in_ready", m[k][24], in_rdy[k])
         `CHK("max_bytes", {m[k][3:0], 3'h0}, max_packet_size[k])
         `CHK("out_tclr", exp_otc[k], out_tc[k])
         `CHK("in_tclr", exp_itc[k], in_tc[k])
      end
   endtask : check_all
   //==========================================================
   // Bus cycles and engine events
   task automatic wr(input logic [31:0] ad, input logic [31:0] dt);
      int k;
      logic o16, dr;
      @(posedge i_sys_clk);
      addr <= ad;
      wdata <= dt;
      wr_stb <= 1'b1;
      @(posedge i_sys_clk);
      wr_stb <= 1'b0;
      k = (ad == UECSR_EP3_ADDR) ? 1 : 0;
      o16 = m[k][16];
      dr = m[k][10];
      if (ad == UECSR_EP2_ADDR || ad == UECSR_EP3_ADDR) begin
         if (dt[7]) m[k][3:0] = dt[3:0];
         if (dt[15]) m[k][12:8] = dt[12:8];
         if (!dr) begin
            m[k] = m[k] & ~(dt & 32'h00450000);
            m[k][21] = dt[21];
            exp_otc[k] = dt[23];
            if (o16 && !m[k][16]) m[k][19] = 1'b0;
         end else begin
            m[k] = m[k] & ~(dt & 32'h24000000);
            if (dt[24] && !m[k][28]) m[k][24] = 1'b1;
            m[k][28] = dt[28];
            exp_itc[k] = dt[30];
         end
      end
      #1;
      check_all();
      exp_otc = '0;
      exp_itc = '0;
   endtask : wr
   task automatic rd(input logic [31:0] ad);
      logic [31:0] x;
      @(posedge i_sys_clk);
      addr <= ad;
      rd_stb <= 1'b1;
      @(posedge i_sys_clk);
      rd_stb <= 1'b0;
      x = (ad == UECSR_EP2_ADDR) ? rd_exp(0) : (ad == UECSR_EP3_ADDR) ? rd_exp(1) : '0;
      #1;
      `CHK("rdata", x & 32'hf7efffff, rdata & 32'hf7efffff)
      check_all();
   endtask : rd
   task automatic ev(input int k, input int n);
      logic o16;
      logic dr;
      i_eng.pulse(k, n);
      dr = m[k][10];
      o16 = m[k][16];
      case (n)
         0: if (!dr) m[k][16] = 1'b1;
         1: if (!dr && m[k][8]) m[k][18] = 1'b1;
         2: if (!dr && m[k][8]) m[k][19] = 1'b1;
         3: if (!dr) m[k][22] = 1'b1;
         4: if (m[k][9]) m[k][16] = 1'b0;
         5: m[k][24] = 1'b0;
         6: if (dr && m[k][11] && !m[k][24]) m[k][26] = 1'b1;
         7: if (dr) m[k][29] = 1'b1;
         default: if (dr && m[k][12] && !m[k][28]) m[k][24] = 1'b1;
      endcase
      if (n == 7) m[k][24] = 1'b0;
      if (o16 && !m[k][16]) m[k][19] = 1'b0;
      #1;
      check_all();
   endtask : ev
   // Wait for a flush request to be answered
   task automatic flush_wait(input logic [1:0] fl, input int k);
      repeat (20) if (out_fl[k] || in_fl[k]) @(posedge i_sys_clk);
      #1;
      `CHK("flush_end", 2'b00, {out_fl[k], in_fl[k]})
   endtask : flush_wait
   // Reset in mid-run, endpoint 3 read in the first cycle after release
   task automatic mid_reset();
      @(posedge i_sys_clk);
      i_srst <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      addr <= UECSR_EP3_ADDR;
      rd_stb <= 1'b1;
      @(posedge i_sys_clk);
      rd_stb <= 1'b0;
      m[0] = UECSR_RESET;
      m[1] = UECSR_RESET;
      #1;
      `CHK("rdata_rst", rd_exp(1), rdata)
      check_all();
   endtask : mid_reset
   task automatic test_done();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   //==========================================================
   // Main sequence
   initial begin
      m[0] = UECSR_RESET;
      m[1] = UECSR_RESET;
      exp_otc = '0;
      exp_itc = '0;
      repeat (3) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      rd(UECSR_EP2_ADDR);
      rd(UECSR_EP3_ADDR);
      wr(32'hf00e0028, 32'hffffffff);
      rd(32'hf00e0028);
      $display("test reset done");
      for (e = 0; e < 2; e++) begin
         a = e ? UECSR_EP3_ADDR : UECSR_EP2_ADDR;
         wr(a, 32'h00000f05);
         wr(a, 32'h00000088);
         wr(a, 32'h00008300);
         i_eng.levels(2'b11, 2'b11);
         for (int n = 0; n < 9; n++) begin
            ev(e, n);
            rd(a);
         end
         ev(e, 0);
         wr(a, 32'h00f40000);
         `CHK("out_flush", 1'b1, out_fl[e])
         flush_wait(out_fl, e);
         wr(a, 32'h00019c00);
         for (int n = 0; n < 9; n++) begin
            ev(e, n);
            rd(a);
         end
         wr(a, 32'h7c000000);
         `CHK("in_flush", 1'b1, in_fl[e])
         flush_wait(in_fl, e);
         ev(e, 8);
         wr(a, 32'h11000000);
         wr(a, 32'h01000000);
         ev(e, 6);
         rd(a);
         wr(a, 32'h01000000);
      end
      $display("test directed done");
      mid_reset();
      $display("test mid reset done");
      for (int i = 0; i < 80; i++) begin
         e = $unsigned($random(seed)) % 2;
         d = $random(seed);
         a = e ? UECSR_EP3_ADDR : UECSR_EP2_ADDR;
         case ($unsigned($random(seed)) % 3)
            0: wr(a, d);
            1: ev(e, $unsigned($random(seed)) % 9);
            default: begin
               i_eng.levels(d[1:0], d[3:2]);
               rd(a);
            end
         endcase
      end
      $display("test random done");
      test_done();
   end
endmodule : testbench
